// ==== kpi_pkg.sv ====
// package for the keypad wake unit: register map, field layout, reset values
package kpi_pkg;
  localparam int KPI_NPIN = 8;
  localparam logic [11:0] KPI_OFF_STATUS_CONTROL = 12'h000;
  localparam logic [11:0] KPI_OFF_PIN_ENABLE = 12'h004;
  localparam logic [11:0] KPI_OFF_POLARITY_SELECT = 12'h008;
  localparam logic [11:0] KPI_OFF_IRQ_STATUS = 12'h00c;
  localparam logic [11:0] KPI_OFF_IRQ_MASK = 12'h010;
  localparam int KPI_BIT_MODE = 0;
  localparam int KPI_BIT_REQ_EN = 1;
  localparam int KPI_BIT_ACK = 2;
  localparam int KPI_BIT_FLAG = 3;
  localparam logic [7:0] KPI_PIN_MASK = 8'h37;
  localparam logic [7:0] KPI_SC_WR_MASK = 8'h03;
  localparam logic [7:0] KPI_RESET_BYTE = 8'h00;
  localparam logic [1:0] KPI_IRQ_MASK_BITS = 2'h3;
  localparam int KPI_IRQ_FLAG = 0;
  localparam int KPI_IRQ_WAKE = 1;

  typedef struct packed {
    logic [11:0] addr;
    logic write;
    logic [31:0] wdata;
    logic access;
  } kpi_bus_req_s;

  typedef struct packed {
    logic [7:0] enable;
    logic [7:0] polarity;
    logic edge_level_mode;
  } kpi_cfg_s;
endpackage

// ==== kpi_detect.sv ====
// keypad wake unit pin detector: sampling, edge and level qualification
`timescale 1ns/1ps
module kpi_detect
  import kpi_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [KPI_NPIN-1:0] pins,
  input wire kpi_cfg_s cfg,
  output logic set_flag,
  output logic any_asserted
);
  logic [KPI_NPIN-1:0] asserted_now;
  logic [KPI_NPIN-1:0] armed_q;
  logic [KPI_NPIN-1:0] edge_hit;

  // map each pin to its asserted sense; disabled pins never count
  always_comb begin
    asserted_now = (pins ~^ cfg.polarity) & cfg.enable & KPI_PIN_MASK;
  end

  // a pin arms once seen deasserted, so enabling a held pin gives no edge
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      armed_q <= '0;
    end else begin
      armed_q <= ~asserted_now & cfg.enable & KPI_PIN_MASK;
    end
  end

  // edge: deasserted last clock cycle, asserted this one
  always_comb begin
    edge_hit = armed_q & asserted_now;
    any_asserted = |asserted_now;
    set_flag = (|edge_hit) || (cfg.edge_level_mode && any_asserted);
  end
endmodule

// ==== kpi_top.sv ====
// keypad wake unit top: apb register slave, flag, request and wake logic
`timescale 1ns/1ps
module kpi_top
  import kpi_pkg::*;
(
  // single clock domain and its asynchronous active-low reset
  input wire logic REF_CLK,
  input wire logic NRST,
  // apb slave port; every access completes in its first access cycle
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [11:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  // wake pins, taken as synchronous to the clock; only five are implemented
  input wire logic [KPI_NPIN-1:0] WAKE_INPUT_PIN,
  // high while the power controller holds the part in stop
  input wire logic LOW_POWER_STOP,
  // level request to the processor, wake to the power controller, masked interrupt
  output logic REQUEST,
  output logic WAKE,
  output logic IRQ
);
  // run/stop tracking, so a wake taken in stop can be told apart from a normal set
  typedef enum logic [1:0] {KPI_RUN, KPI_STOPPED} kpi_pwr_e;

  // bus side
  kpi_bus_req_s req;
  logic wr;
  logic mapped;
  logic wr_sc;
  logic wr_pe;
  logic wr_pol;
  logic wr_sts;
  logic wr_msk;
  logic rd_setup;
  logic [31:0] rdata_d;

  // configuration registers and the bundle handed to the detector
  kpi_cfg_s cfg;
  logic mode_q;
  logic req_en_q;
  logic [7:0] enable_q;
  logic [7:0] polarity_q;

  // detector results and the shared event flag
  logic set_flag;
  logic any_asserted;
  logic flag_q;
  logic ack_wr;
  logic flag_clr;

  // power state and the clockless wake path
  kpi_pwr_e pwr_q;
  logic [KPI_NPIN-1:0] pins_asserted;
  logic async_wake;
  logic stop_event;

  // sticky interrupt status and its mask
  logic [1:0] irq_status_q;
  logic [1:0] irq_mask_q;
  logic [1:0] irq_set;
  logic [1:0] irq_clr;

  // decode one register offset from the bus address
  function automatic logic hit(input logic [11:0] a, input logic [11:0] off);
    return a == off;
  endfunction

  // pins that stand at their asserted level, limited to enabled, implemented pins
  function automatic logic [KPI_NPIN-1:0] level_of(input logic [KPI_NPIN-1:0] p, input logic [7:0] pol,
    input logic [7:0] en);
    return (p ~^ pol) & en & KPI_PIN_MASK;
  endfunction

  // an 8-bit register read back in the low byte of the bus word; upper bits read zero
  function automatic logic [31:0] byte_word(input logic [7:0] b);
    return {24'h00_0000, b};
  endfunction

  // bundle the bus request
  always_comb begin
    req.addr = PADDR;
    req.write = PWRITE;
    req.wdata = PWDATA;
    req.access = PSEL && PENABLE;
  end

  // zero wait-state slave: every access ends in its first access cycle
  assign PREADY = 1'b1;
  assign wr = req.access && req.write;
  // read data is launched in the setup cycle, a cycle before the access samples it
  assign rd_setup = PSEL && !PENABLE && !PWRITE;

  always_comb begin
    mapped = hit(req.addr, KPI_OFF_STATUS_CONTROL) || hit(req.addr, KPI_OFF_PIN_ENABLE)
      || hit(req.addr, KPI_OFF_POLARITY_SELECT) || hit(req.addr, KPI_OFF_IRQ_STATUS)
      || hit(req.addr, KPI_OFF_IRQ_MASK);
  end

  // unmapped addresses answer with an error and read zero
  assign PSLVERR = req.access && !mapped;

  // one write strobe per register, decoded once and shared by the flops below
  always_comb begin
    wr_sc = wr && hit(req.addr, KPI_OFF_STATUS_CONTROL);
    wr_pe = wr && hit(req.addr, KPI_OFF_PIN_ENABLE);
    wr_pol = wr && hit(req.addr, KPI_OFF_POLARITY_SELECT);
    wr_sts = wr && hit(req.addr, KPI_OFF_IRQ_STATUS);
    wr_msk = wr && hit(req.addr, KPI_OFF_IRQ_MASK);
  end

  // configuration bundle for the detector
  always_comb begin
    cfg.enable = enable_q;
    cfg.polarity = polarity_q;
    cfg.edge_level_mode = mode_q;
  end

  // detector runs on every clock; debug halt does not touch it,
  // and wait mode leaves the clock running, so detection simply carries on
  kpi_detect u_detect (
    .clk(REF_CLK),
    .rst_n(NRST),
    .pins(WAKE_INPUT_PIN),
    .cfg(cfg),
    .set_flag(set_flag),
    .any_asserted(any_asserted)
  );

  // control bits of the status/control register
  always_ff @(posedge REF_CLK or negedge NRST) begin
    if (!NRST) begin
      mode_q <= 1'b0;
      req_en_q <= 1'b0;
    end else if (wr_sc) begin
      mode_q <= req.wdata[KPI_BIT_MODE];
      req_en_q <= req.wdata[KPI_BIT_REQ_EN];
    end
  end

  // pin enable register, only implemented pins hold a bit
  always_ff @(posedge REF_CLK or negedge NRST) begin
    if (!NRST) begin
      enable_q <= KPI_RESET_BYTE;
    end else if (wr_pe) begin
      enable_q <= req.wdata[7:0] & KPI_PIN_MASK;
    end
  end

  // polarity select register
  always_ff @(posedge REF_CLK or negedge NRST) begin
    if (!NRST) begin
      polarity_q <= KPI_RESET_BYTE;
    end else if (wr_pol) begin
      polarity_q <= req.wdata[7:0] & KPI_PIN_MASK;
    end
  end

  // acknowledge: a one written to bit 2 of status/control
  assign ack_wr = wr_sc && req.wdata[KPI_BIT_ACK];
  // in level mode an asserted pin blocks the clear
  assign flag_clr = ack_wr && !(mode_q && any_asserted);

  // event flag: set wins over clear so a same-cycle event is kept
  always_ff @(posedge REF_CLK or negedge NRST) begin
    if (!NRST) begin
      flag_q <= 1'b0;
    end else if (set_flag) begin
      flag_q <= 1'b1;
    end else if (flag_clr) begin
      flag_q <= 1'b0;
    end
  end

  // stop state: clock may be gated outside, so wake is combinational from pins
  always_ff @(posedge REF_CLK or negedge NRST) begin
    if (!NRST) begin
      pwr_q <= KPI_RUN;
    end else begin
      case (pwr_q)
        KPI_RUN: if (LOW_POWER_STOP) pwr_q <= KPI_STOPPED;
        KPI_STOPPED: if (!LOW_POWER_STOP) pwr_q <= KPI_RUN;
        default: pwr_q <= KPI_RUN;
      endcase
    end
  end

  // asynchronous path: with request enable set, any enabled asserted pin raises wake while stopped;
  // it bypasses every flop because the clock may be gated outside in stop
  always_comb begin
    pins_asserted = level_of(WAKE_INPUT_PIN, polarity_q, enable_q);
    async_wake = LOW_POWER_STOP && req_en_q && (|pins_asserted);
  end

  // a wake seen while already stopped is recorded for software
  always_comb begin
    stop_event = (pwr_q == KPI_STOPPED) && async_wake;
  end

  assign REQUEST = flag_q && req_en_q;
  assign WAKE = REQUEST || async_wake;

  // status events: one bit for each flag set, one for a wake taken while stopped
  always_comb begin
    irq_set = 2'h0;
    irq_set[KPI_IRQ_FLAG] = set_flag;
    irq_set[KPI_IRQ_WAKE] = stop_event;
  end

  // write one to clear; a zero written leaves the bit alone
  always_comb begin
    irq_clr = 2'h0;
    if (wr_sts) begin
      irq_clr = req.wdata[1:0] & KPI_IRQ_MASK_BITS;
    end
  end

  // sticky interrupt status; set wins over a same-cycle clear so no event is lost
  always_ff @(posedge REF_CLK or negedge NRST) begin
    if (!NRST) begin
      irq_status_q <= 2'h0;
    end else begin
      irq_status_q <= (irq_status_q & ~irq_clr) | irq_set;
    end
  end

  // interrupt mask
  always_ff @(posedge REF_CLK or negedge NRST) begin
    if (!NRST) begin
      irq_mask_q <= 2'h0;
    end else if (wr_msk) begin
      irq_mask_q <= req.wdata[1:0] & KPI_IRQ_MASK_BITS;
    end
  end

  assign IRQ = |(irq_status_q & irq_mask_q);

  // read mux; acknowledge bit always reads zero
  always_comb begin
    rdata_d = 32'h0000_0000;
    if (hit(req.addr, KPI_OFF_STATUS_CONTROL)) begin
      rdata_d[KPI_BIT_FLAG] = flag_q;
      rdata_d[KPI_BIT_ACK] = 1'b0;
      rdata_d[KPI_BIT_REQ_EN] = req_en_q;
      rdata_d[KPI_BIT_MODE] = mode_q;
    end else if (hit(req.addr, KPI_OFF_PIN_ENABLE)) begin
      rdata_d = byte_word(enable_q);
    end else if (hit(req.addr, KPI_OFF_POLARITY_SELECT)) begin
      rdata_d = byte_word(polarity_q);
    end else if (hit(req.addr, KPI_OFF_IRQ_STATUS)) begin
      rdata_d[1:0] = irq_status_q;
    end else if (hit(req.addr, KPI_OFF_IRQ_MASK)) begin
      rdata_d[1:0] = irq_mask_q;
    end
  end

  // read data captured at setup so it is a flop output during access;
  // the cost is that a flag set in the access cycle shows on the next read
  always_ff @(posedge REF_CLK or negedge NRST) begin
    if (!NRST) begin
      PRDATA <= 32'h0000_0000;
    end else if (rd_setup) begin
      PRDATA <= rdata_d;
    end
  end
endmodule

// ==== kpi_assertions.sv ====
// checker of the keypad wake unit port behaviour
`timescale 1ns/1ps
module kpi_chk
  import kpi_pkg::*;
(
  input wire logic REF_CLK,
  input wire logic NRST,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [11:0] PADDR,
  input wire logic [31:0] PWDATA,
  input wire logic [31:0] PRDATA,
  input wire logic PREADY,
  input wire logic [KPI_NPIN-1:0] WAKE_INPUT_PIN,
  input wire logic LOW_POWER_STOP,
  input wire logic REQUEST,
  input wire logic WAKE
);
  default clocking cb @(posedge REF_CLK); endclocking
  default disable iff (!NRST);
  logic [1:0] sc_q;
  logic [7:0] pe_q, pol_q, pin_q;
  wire wr = PSEL & PENABLE & PWRITE & PREADY;
  wire wsc = wr && PADDR == KPI_OFF_STATUS_CONTROL;
  wire ack = wsc && PWDATA[KPI_BIT_ACK];
  wire [7:0] asrt = pe_q & ~(WAKE_INPUT_PIN ^ pol_q);
  wire [7:0] edg = asrt & (pin_q ^ pol_q);
  // shadow of the configuration, so flag rules can be judged from the ports alone
  always_ff @(posedge REF_CLK or negedge NRST) begin
    if (!NRST) begin
      sc_q <= 2'h0;
      pe_q <= 8'h00;
      pol_q <= 8'h00;
      pin_q <= 8'h00;
    end else begin
      pin_q <= WAKE_INPUT_PIN;
      if (wsc) sc_q <= PWDATA[1:0];
      if (wr && PADDR == KPI_OFF_PIN_ENABLE) pe_q <= PWDATA[7:0] & KPI_PIN_MASK;
      if (wr && PADDR == KPI_OFF_POLARITY_SELECT) pol_q <= PWDATA[7:0];
    end
  end
  // pins quiet for two samples, so no set can race the acknowledge
  sequence s_ack_edge; ack && PWDATA[1:0] == 2'h2 && !sc_q[0] && WAKE_INPUT_PIN == pin_q; endsequence
  sequence s_lvl; sc_q == 2'h3 && |asrt; endsequence
  property p_rst; disable iff (1'b0) !NRST |-> !REQUEST && !WAKE; endproperty
  property p_gate; REQUEST |-> sc_q[1]; endproperty
  property p_ackrd;
    PSEL && PENABLE && !PWRITE && PADDR == KPI_OFF_STATUS_CONTROL |-> PRDATA[2:0] == {1'b0, $past(sc_q)};
  endproperty
  property p_flag_ro; wsc && !PWDATA[2] && PWDATA[1] && REQUEST |=> REQUEST; endproperty
  property p_clear; s_ack_edge |=> !REQUEST; endproperty
  property p_hold; ((REQUEST && ack && PWDATA[1:0] == 2'h3) and s_lvl) |=> REQUEST; endproperty
  // a write to the control register may drop the request enable at the same edge
  property p_level; s_lvl [*2] ##0 !wsc |=> REQUEST; endproperty
  property p_edge; sc_q[1] && |(edg & $past(pe_q)) |-> ##2 REQUEST; endproperty
  property p_off; sc_q[1] && !REQUEST && pe_q == 8'h00 && $past(pe_q, 2) == 8'h00 |=> !REQUEST; endproperty
  property p_wake; REQUEST || (LOW_POWER_STOP && sc_q[1] && |asrt) |-> WAKE; endproperty
  a_rst: assert property (p_rst) else $error("output active in reset");
  a_gate: assert property (p_gate) else $error("request while disabled");
  a_ackrd: assert property (p_ackrd) else $error("control readback wrong");
  a_flag_ro: assert property (p_flag_ro) else $error("flag changed by write");
  a_clear: assert property (p_clear) else $error("flag not cleared");
  a_hold: assert property (p_hold) else $error("flag cleared while asserted");
  a_level: assert property (p_level) else $error("level not flagged");
  a_edge: assert property (p_edge) else $error("edge not flagged");
  a_off: assert property (p_off) else $error("disabled pin flagged");
  a_wake: assert property (p_wake) else $error("no wake");
endmodule
bind kpi_top kpi_chk u_chk (.REF_CLK, .NRST, .PSEL, .PENABLE, .PWRITE, .PADDR, .PWDATA, .PRDATA, .PREADY,
  .WAKE_INPUT_PIN, .LOW_POWER_STOP, .REQUEST, .WAKE);

// ==== kpi_keys.sv ====
// switch model on the wake pins, each line pulled to its idle level
`timescale 1ns/1ps
module kpi_keys (
  input wire logic [7:0] press,
  input wire logic [7:0] idle,
  output logic [7:0] pins
);
  // a pressed key pulls its line away from the pull level
  assign pins = press ^ idle;
endmodule

// ==== test_keypad_pin_interrupt.sv ====
// self-checking bench of the keypad wake unit
`timescale 1ns/1ps
module test_keypad_pin_interrupt
  import kpi_pkg::*;
;
  logic clk = 1'b0, nrst = 1'b1, psel = 1'b0, pen = 1'b0, pwr = 1'b0, stop = 1'b0;
  logic rerr = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, rdat;
  logic [7:0] press = 8'h00, idle = 8'hff;
  wire [7:0] pins;
  wire [31:0] prdata;
  wire pready, perr, req, wake, irq;
  int n_fail = 0, cmp_count = 0;
  always #2.5 clk = ~clk;
  kpi_keys keys (.press(press), .idle(idle), .pins(pins));
  kpi_top dut (.REF_CLK(clk), .NRST(nrst), .PSEL(psel), .PENABLE(pen), .PWRITE(pwr), .PADDR(paddr),
    .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(perr), .WAKE_INPUT_PIN(pins),
    .LOW_POWER_STOP(stop), .REQUEST(req), .WAKE(wake), .IRQ(irq));
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      n_fail++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic nap(input int n);
    repeat (n) @(posedge clk);
  endtask
  // one transfer, then an idle cycle so the next setup never lands on the release
  task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwr <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    pen <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    rdat = prdata;
    rerr = perr;
    psel <= 1'b0;
    pen <= 1'b0;
    @(posedge clk);
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    chk(rdat, e);
  endtask
  // mode, polarity, enables, acknowledge, then request enable
  task automatic cfg(input logic [7:0] pol, input logic [7:0] pe, input logic m);
    press <= 8'h00;
    wr(KPI_OFF_STATUS_CONTROL, {31'h0, m});
    idle <= ~pol;
    wr(KPI_OFF_POLARITY_SELECT, {24'h0, pol});
    wr(KPI_OFF_PIN_ENABLE, {24'h0, pe});
    wr(KPI_OFF_STATUS_CONTROL, {29'h0, 1'b1, 1'b0, m});
    wr(KPI_OFF_STATUS_CONTROL, {30'h0, 1'b1, m});
  endtask
  task automatic t_reset;
    for (int a = 0; a < 5; a++) rd(12'(a * 4), 32'h0);
    chk(32'(req), 32'h1 - 32'h1);
    $display("reset test done");
  endtask
  task automatic t_edge;
    for (int p = 0; p < 2; p++) begin
      cfg({8{p[0]}}, 8'h37, 1'b0);
      press <= 8'h10;
      nap(6);
      chk(32'(req), 32'h1);
      rd(KPI_OFF_STATUS_CONTROL, 32'h0a);
      wr(KPI_OFF_STATUS_CONTROL, 32'h02);
      chk(32'(req), 32'h1);
      press <= 8'h00;
      nap(3);
      wr(KPI_OFF_STATUS_CONTROL, 32'h06);
      chk(32'(req), 32'h0);
      rd(KPI_OFF_STATUS_CONTROL, 32'h02);
    end
    $display("edge test done");
  endtask
  task automatic t_disabled;
    cfg(8'h00, 8'h27, 1'b0);
    press <= 8'hd8;
    nap(6);
    chk(32'(req), 32'h0);
    press <= 8'hf8;
    nap(6);
    chk(32'(req), 32'h1);
    $display("enable test done");
  endtask
  task automatic t_level;
    cfg(8'h00, 8'h01, 1'b1);
    press <= 8'h01;
    nap(6);
    chk(32'(req), 32'h1);
    wr(KPI_OFF_STATUS_CONTROL, 32'h07);
    chk(32'(req), 32'h1);
    wr(KPI_OFF_STATUS_CONTROL, 32'h05);
    chk(32'(req), 32'h0);
    rd(KPI_OFF_STATUS_CONTROL, 32'h09);
    press <= 8'h00;
    nap(3);
    wr(KPI_OFF_STATUS_CONTROL, 32'h07);
    chk(32'(req), 32'h0);
    $display("level test done");
  endtask
  // a pin enabled while asserted must first be seen released
  task automatic t_late_enable;
    cfg(8'h00, 8'h00, 1'b0);
    press <= 8'h01;
    nap(4);
    wr(KPI_OFF_PIN_ENABLE, 32'h01);
    nap(6);
    chk(32'(req), 32'h0);
    press <= 8'h00;
    nap(3);
    press <= 8'h01;
    nap(6);
    chk(32'(req), 32'h1);
    $display("late enable test done");
  endtask
  task automatic t_stop;
    chk(32'(irq), 32'h0);
    wr(KPI_OFF_IRQ_MASK, 32'h01);
    chk(32'(irq), 32'h1);
    wr(KPI_OFF_IRQ_STATUS, 32'h03);
    chk(32'(irq), 32'h0);
    wr(KPI_OFF_STATUS_CONTROL, 32'h06);
    chk(32'(req), 32'h0);
    stop <= 1'b1;
    press <= 8'h00;
    nap(3);
    chk(32'(wake), 32'h0);
    press <= 8'h01;
    nap(1);
    chk(32'(wake), 32'h1);
    stop <= 1'b0;
    rd(12'h020, 32'h0);
    chk(32'(rerr), 32'h1);
    rd(KPI_OFF_IRQ_STATUS, 32'h3);
    $display("stop test done");
  endtask
  task automatic results;
    $display("comparisons %0d mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  initial begin
    #200000;
    n_fail++;
    results();
  end
  initial begin
    nrst <= 1'b0;
    nap(10);
    nrst <= 1'b1;
    nap(1);
    t_reset();
    t_edge();
    t_disabled();
    t_level();
    t_late_enable();
    t_stop();
    results();
  end
endmodule
